// file: core/srs_buffer.sv
`default_nettype none

// ------------------------------------------------------------------
// Shift-style buffer: head entry always in slot 0
// ------------------------------------------------------------------
module srs_buffer #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 2
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic out_ready_i
);

	logic [WIDTH-1:0] slot_reg [DEPTH];
	logic [DEPTH-1:0] vld_reg;
	logic pop;
	logic push;

	assign pop = vld_reg[0] & out_ready_i;
	assign push = in_valid_i & in_ready_o;
	assign in_ready_o = ~vld_reg[DEPTH-1];
	assign out_valid_o = vld_reg[0];
	assign out_data_o = slot_reg[0];

	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi++) begin : g_slot
			logic up_v;
			logic low_v;
			logic cur_v;
			logic [WIDTH-1:0] up_d;
			if (gi == DEPTH - 1) begin : g_top
				assign up_v = 1'b0;
				assign up_d = slot_reg[gi];
			end else begin : g_mid
				assign up_v = vld_reg[gi+1];
				assign up_d = slot_reg[gi+1];
			end
			if (gi == 0) begin : g_first
				assign low_v = 1'b1;
			end else begin : g_rest
				assign low_v = pop ? vld_reg[gi] : vld_reg[gi-1];
			end
			assign cur_v = pop ? up_v : vld_reg[gi];
			always_ff @(posedge clk_i) begin
				if (!rst_n_i) begin
					vld_reg[gi] <= 1'b0;
				end else begin
					if (push && !cur_v && low_v) begin
						vld_reg[gi] <= 1'b1;
						slot_reg[gi] <= in_data_i;
					end else begin
						vld_reg[gi] <= cur_v;
						if (pop) begin
							slot_reg[gi] <= up_d;
						end
					end
				end
			end
		end
	endgenerate

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	a_full_refuse: assert property (vld_reg[DEPTH-1] && !pop |=> vld_reg[DEPTH-1]
		&& $stable(slot_reg[DEPTH-1]) && $stable(slot_reg[0]))
		else $error("buffer took a word while full");
	a_pop_order: assert property (pop && !vld_reg[1] && !push |=> !vld_reg[0])
		else $error("buffer kept a popped word");

endmodule

`default_nettype wire

// file: core/srs_pkg.sv
`default_nettype none

package srs_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 20000000;
	// Time the bus bias must settle before the port decides to enable
	localparam int BIAS_SETTLE_NS = 1000;
	localparam int BIAS_SETTLE_CYC = (BIAS_SETTLE_NS * (CLK_HZ / 1000000) + 999) / 1000;

	// ----------------------------------------------------------------
	// Protocol fields and reset values
	// ----------------------------------------------------------------
	localparam int ADDR_W = 7;
	localparam int BYTE_W = 8;
	localparam int RW_BIT = 0;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [7:0] PTR_RESET = 8'h00;
	// Value is arbitrary
	localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h2c;
	// Pointers at or above this reach run-time registers
	localparam logic [7:0] RUNTIME_BASE_DEFAULT = 8'hc0;

	typedef enum logic [3:0] {
		SRS_OFF,
		SRS_IDLE,
		SRS_ADDR,
		SRS_PTR,
		SRS_WDATA,
		SRS_RFETCH,
		SRS_RDATA,
		SRS_RACK,
		SRS_IGNORE
	} srs_state_e;

endpackage

`default_nettype wire

// file: core/srs_slave.sv
`default_nettype none

// What this block does
// - First byte after write address loads the 8-bit register pointer.
// - Each later write byte not refused by the configuration lock stores at pointer, is acked, then pointer increments.
// - Write burst continues into successive registers until a Stop.
// - Each read byte returns register at pointer, then pointer increments.
// - Host nacks last read byte; device then releases the data line.
// - Without Stop, read opens with Repeated Start; pointer kept either way.
// - Port enabled only when both lines show pull-up bias.
// - Port stays disabled until the next reset if the data line is low when bias is sampled.
// - Host reads and writes run-time and memory-programming registers through port.
// - Configuration writes accepted only before hub attaches upstream.
module srs_slave #(
	parameter logic [6:0] SLAVE_ADDR = srs_pkg::SLAVE_ADDR_DEFAULT,
	parameter logic [7:0] RUNTIME_BASE = srs_pkg::RUNTIME_BASE_DEFAULT,
	parameter int BUF_DEPTH = 2
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic serial_clock_line_i,
	output logic serial_clock_line_o,
	output logic serial_clock_line_oe_o,
	input wire logic serial_data_line_i,
	output logic serial_data_line_o,
	output logic serial_data_line_oe_o,
	input wire logic hub_attached_i,
	output logic port_enabled_o,
	output logic [7:0] pointer_o,
	output logic rd_req_o,
	output logic [7:0] rd_addr_o,
	input wire logic rd_valid_i,
	input wire logic [7:0] rd_data_i,
	output logic wr_valid_o,
	output logic [7:0] wr_addr_o,
	output logic [7:0] wr_data_o,
	input wire logic wr_ready_i
);

	srs_pkg::srs_state_e state_reg;
	logic scl_q_reg;
	logic sda_q_reg;
	logic [7:0] shift_reg;
	logic [3:0] bit_cnt_reg;
	logic ack_phase_reg;
	logic read_next_reg;
	logic mack_reg;
	logic [7:0] ptr_reg;
	logic sda_oe_reg;
	logic scl_oe_reg;
	logic rd_req_reg;
	logic [15:0] settle_reg;
	logic en_reg;

	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic byte_done;
	logic addr_match;
	logic cfg_locked;
	logic push;
	logic buf_ready;
	logic [15:0] buf_out;

	// ----------------------------------------------------------------
	// Line edges and bus conditions
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			scl_q_reg <= 1'b1;
			sda_q_reg <= 1'b1;
		end else begin
			scl_q_reg <= serial_clock_line_i;
			sda_q_reg <= serial_data_line_i;
		end
	end

	assign scl_rise = serial_clock_line_i & ~scl_q_reg;
	assign scl_fall = ~serial_clock_line_i & scl_q_reg;
	assign start_det = sda_q_reg & ~serial_data_line_i & serial_clock_line_i & scl_q_reg;
	assign stop_det = ~sda_q_reg & serial_data_line_i & serial_clock_line_i & scl_q_reg;
	assign byte_done = (bit_cnt_reg == srs_pkg::BITS_PER_BYTE) & ~ack_phase_reg;
	assign addr_match = shift_reg[7:1] == SLAVE_ADDR;
	assign cfg_locked = hub_attached_i & (ptr_reg < RUNTIME_BASE);
	// A stalled byte is pushed later, while the clock is still stretched
	assign push = (state_reg == srs_pkg::SRS_WDATA) & (scl_fall | scl_oe_reg) & byte_done
		& ~cfg_locked & buf_ready;

	// ----------------------------------------------------------------
	// Bias detection after reset
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			settle_reg <= 16'h0000;
			en_reg <= 1'b0;
		end else if (settle_reg < 16'(srs_pkg::BIAS_SETTLE_CYC)) begin
			settle_reg <= settle_reg + 16'h0001;
			if (settle_reg == 16'(srs_pkg::BIAS_SETTLE_CYC - 1)) begin
				en_reg <= serial_data_line_i & serial_clock_line_i;
			end
		end
	end

	// ----------------------------------------------------------------
	// Protocol state machine
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_reg <= srs_pkg::SRS_OFF;
			shift_reg <= 8'h00;
			bit_cnt_reg <= 4'h0;
			ack_phase_reg <= 1'b0;
			read_next_reg <= 1'b0;
			mack_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
			scl_oe_reg <= 1'b0;
			rd_req_reg <= 1'b0;
		end else begin
			rd_req_reg <= 1'b0;
			if (state_reg == srs_pkg::SRS_OFF) begin
				if (en_reg) begin
					state_reg <= srs_pkg::SRS_IDLE;
				end
			end else if (stop_det) begin
				state_reg <= srs_pkg::SRS_IDLE;
				sda_oe_reg <= 1'b0;
				scl_oe_reg <= 1'b0;
				ack_phase_reg <= 1'b0;
			end else if (start_det) begin
				state_reg <= srs_pkg::SRS_ADDR;
				bit_cnt_reg <= 4'h0;
				ack_phase_reg <= 1'b0;
				sda_oe_reg <= 1'b0;
				scl_oe_reg <= 1'b0;
			end else begin
				case (state_reg)
					srs_pkg::SRS_IDLE, srs_pkg::SRS_IGNORE: begin
						sda_oe_reg <= 1'b0;
					end
					srs_pkg::SRS_ADDR, srs_pkg::SRS_PTR, srs_pkg::SRS_WDATA: begin
						if (scl_rise && !ack_phase_reg && bit_cnt_reg < srs_pkg::BITS_PER_BYTE) begin
							shift_reg <= {shift_reg[6:0], serial_data_line_i};
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
						end else if (scl_fall && ack_phase_reg) begin
							sda_oe_reg <= 1'b0;
							ack_phase_reg <= 1'b0;
							bit_cnt_reg <= 4'h0;
							if (read_next_reg) begin
								state_reg <= srs_pkg::SRS_RFETCH;
								scl_oe_reg <= 1'b1;
								rd_req_reg <= 1'b1;
							end
						end else if ((scl_fall || scl_oe_reg) && byte_done) begin
							case (state_reg)
								srs_pkg::SRS_ADDR: begin
									if (addr_match) begin
										sda_oe_reg <= 1'b1;
										ack_phase_reg <= 1'b1;
										read_next_reg <= shift_reg[srs_pkg::RW_BIT];
										if (!shift_reg[srs_pkg::RW_BIT]) begin
											state_reg <= srs_pkg::SRS_PTR;
										end
									end else begin
										state_reg <= srs_pkg::SRS_IGNORE;
									end
								end
								srs_pkg::SRS_PTR: begin
									sda_oe_reg <= 1'b1;
									ack_phase_reg <= 1'b1;
									read_next_reg <= 1'b0;
									state_reg <= srs_pkg::SRS_WDATA;
								end
								default: begin
									if (cfg_locked) begin
										ack_phase_reg <= 1'b1;
										scl_oe_reg <= 1'b0;
									end else if (buf_ready) begin
										sda_oe_reg <= 1'b1;
										ack_phase_reg <= 1'b1;
										scl_oe_reg <= 1'b0;
									end else begin
										scl_oe_reg <= 1'b1;
									end
								end
							endcase
						end
					end
					srs_pkg::SRS_RFETCH: begin
						if (rd_valid_i) begin
							shift_reg <= rd_data_i;
							sda_oe_reg <= ~rd_data_i[7];
							bit_cnt_reg <= 4'h1;
							scl_oe_reg <= 1'b0;
							state_reg <= srs_pkg::SRS_RDATA;
						end
					end
					srs_pkg::SRS_RDATA: begin
						if (scl_fall) begin
							if (bit_cnt_reg == srs_pkg::BITS_PER_BYTE) begin
								sda_oe_reg <= 1'b0;
								state_reg <= srs_pkg::SRS_RACK;
							end else begin
								shift_reg <= {shift_reg[6:0], 1'b0};
								sda_oe_reg <= ~shift_reg[6];
								bit_cnt_reg <= bit_cnt_reg + 4'h1;
							end
						end
					end
					srs_pkg::SRS_RACK: begin
						if (scl_rise) begin
							mack_reg <= ~serial_data_line_i;
						end else if (scl_fall) begin
							if (mack_reg) begin
								state_reg <= srs_pkg::SRS_RFETCH;
								scl_oe_reg <= 1'b1;
								rd_req_reg <= 1'b1;
							end else begin
								state_reg <= srs_pkg::SRS_IDLE;
								sda_oe_reg <= 1'b0;
							end
						end
					end
					default: begin
						state_reg <= srs_pkg::SRS_IDLE;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Register pointer, shared by write and read transfers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ptr_reg <= srs_pkg::PTR_RESET;
		end else if (state_reg == srs_pkg::SRS_PTR && (scl_fall || scl_oe_reg) && byte_done) begin
			ptr_reg <= shift_reg;
		end else if (push) begin
			ptr_reg <= ptr_reg + 8'h01;
		end else if (state_reg == srs_pkg::SRS_RFETCH && rd_valid_i) begin
			ptr_reg <= ptr_reg + 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// Write path through the buffer; a full buffer stretches the clock
	// ----------------------------------------------------------------
	srs_buffer #(
		.WIDTH(16),
		.DEPTH(BUF_DEPTH)
	) u_wbuf (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.in_valid_i(push),
		.in_data_i({ptr_reg, shift_reg}),
		.in_ready_o(buf_ready),
		.out_valid_o(wr_valid_o),
		.out_data_o(buf_out),
		.out_ready_i(wr_ready_i)
	);

	assign wr_addr_o = buf_out[15:8];
	assign wr_data_o = buf_out[7:0];

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			serial_clock_line_o <= 1'b0;
			serial_data_line_o <= 1'b0;
		end else begin
			serial_clock_line_o <= 1'b0;
			serial_data_line_o <= 1'b0;
		end
	end

	assign serial_data_line_oe_o = sda_oe_reg;
	assign serial_clock_line_oe_o = scl_oe_reg;
	assign port_enabled_o = en_reg;
	assign pointer_o = ptr_reg;
	assign rd_req_o = rd_req_reg;
	assign rd_addr_o = ptr_reg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_ptr_byte;
		state_reg == srs_pkg::SRS_PTR && (scl_fall || scl_oe_reg) && byte_done;
	endsequence

	sequence s_fetch_done;
		state_reg == srs_pkg::SRS_RFETCH && rd_valid_i;
	endsequence

	a_ptr_load: assert property (s_ptr_byte |=> ptr_reg == $past(shift_reg))
		else $error("pointer byte not loaded");
	a_push_inc: assert property (push |=> ptr_reg == $past(ptr_reg) + 8'h01)
		else $error("pointer not incremented after write");
	a_stop_idle: assert property (stop_det && en_reg |=>
		state_reg == srs_pkg::SRS_IDLE && !sda_oe_reg)
		else $error("stop did not end transfer");
	a_read_inc: assert property (s_fetch_done |=>
		ptr_reg == $past(ptr_reg) + 8'h01 && state_reg == srs_pkg::SRS_RDATA)
		else $error("read did not advance pointer");
	a_nack_release: assert property (state_reg == srs_pkg::SRS_RACK && scl_fall
		&& !mack_reg && !start_det && !stop_det |=> !sda_oe_reg ##1 !sda_oe_reg)
		else $error("data line held after nack");
	a_start_keeps: assert property (start_det |=> $stable(ptr_reg))
		else $error("pointer lost on start");
	a_off_quiet: assert property (!en_reg |-> !sda_oe_reg && !scl_oe_reg)
		else $error("disabled port drove a line");
	a_lock_write: assert property (state_reg == srs_pkg::SRS_WDATA && cfg_locked
		&& byte_done && (scl_fall || scl_oe_reg) |=> !sda_oe_reg && $stable(ptr_reg))
		else $error("locked write accepted");
	a_reset_ptr: assert property ($rose(rst_n_i) |-> ptr_reg == srs_pkg::PTR_RESET)
		else $error("pointer not cleared by reset");

endmodule

`default_nettype wire

// file: verification/srs_host_model.sv
`default_nettype none

// ----
// Two-wire host: open-drain pulls, waits out clock stretching
// ----
module srs_host_model #(
	parameter int T = 4
) (
	input wire logic clk_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output var logic scl_low_o,
	output var logic sda_low_o,
	output var logic hang_o
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		scl_low_o = 1'b0;
		sda_low_o = 1'b0;
		hang_o = 1'b0;
	end

	task automatic tick();
		repeat (T) @(posedge clk_i);
	endtask

	task automatic rise();
		int n;
		n = 0;
		scl_low_o <= 1'b0;
		@(posedge clk_i);
		while (scl_i !== 1'b1 && n < 3000) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 3000) hang_o <= 1'b1;
		tick();
	endtask

	task automatic bit_io(input logic b, output logic r);
		sda_low_o <= !b;
		tick();
		rise();
		r = sda_i;
		scl_low_o <= 1'b1;
		tick();
	endtask

	task automatic start();
		sda_low_o <= 1'b0;
		tick();
		rise();
		sda_low_o <= 1'b1;
		tick();
		scl_low_o <= 1'b1;
		tick();
	endtask

	task automatic stop();
		sda_low_o <= 1'b1;
		tick();
		rise();
		sda_low_o <= 1'b0;
		tick();
	endtask

	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, ack);
	endtask

	task automatic rd_byte(input logic nack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(nack, r);
	endtask
endmodule

`default_nettype wire

// file: verification/srs_slave_tb.sv
`default_nettype none

module srs_slave_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [6:0] SA = srs_pkg::SLAVE_ADDR_DEFAULT;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic bias_low = 1'b0;
	logic hub_att = 1'b0;
	logic stall = 1'b0;
	logic wr_ready = 1'b1;
	logic rd_valid = 1'b0;
	logic [7:0] rd_data = 8'h00;
	logic [7:0] ra = 8'h00;
	logic [7:0] mem [256];
	int rd_wait = 0;
	int bad_count = 0;
	int cmp_count = 0;
	logic scl_low, sda_low, hang, scl_oe, sda_oe, scl_out, sda_out, port_en, rd_req, wr_valid;
	logic [7:0] ptr, rd_addr, wr_addr, wr_data;
	wire logic scl;
	wire logic sda;

	assign scl = !scl_low && (scl_oe ? scl_out : 1'b1);
	assign sda = !sda_low && !bias_low && (sda_oe ? sda_out : 1'b1);

	always #25 clk = ~clk;

	srs_slave u_srs_slave (
		.clk_i(clk),
		.rst_n_i(rst_n),
		.serial_clock_line_i(scl),
		.serial_clock_line_o(scl_out),
		.serial_clock_line_oe_o(scl_oe),
		.serial_data_line_i(sda),
		.serial_data_line_o(sda_out),
		.serial_data_line_oe_o(sda_oe),
		.hub_attached_i(hub_att),
		.port_enabled_o(port_en),
		.pointer_o(ptr),
		.rd_req_o(rd_req),
		.rd_addr_o(rd_addr),
		.rd_valid_i(rd_valid),
		.rd_data_i(rd_data),
		.wr_valid_o(wr_valid),
		.wr_addr_o(wr_addr),
		.wr_data_o(wr_data),
		.wr_ready_i(wr_ready)
	);

	srs_host_model u_srs_host_model (
		.clk_i(clk),
		.scl_i(scl),
		.sda_i(sda),
		.scl_low_o(scl_low),
		.sda_low_o(sda_low),
		.hang_o(hang)
	);

	// ----
	// Register space behind the block, slow read answer
	// ----
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = 8'(i) + 8'h11;
	end

	always @(posedge clk) begin
		rd_valid <= 1'b0;
		wr_ready <= !stall;
		if (wr_valid && wr_ready) mem[wr_addr] <= wr_data;
		if (rd_req) begin
			rd_wait <= 3;
			ra <= rd_addr;
		end else if (rd_wait > 0) begin
			rd_wait <= rd_wait - 1;
			if (rd_wait == 1) begin
				rd_valid <= 1'b1;
				rd_data <= mem[ra];
			end
		end
	end

	// ----
	// Checks and scenarios
	// ----
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		chk8({7'h00, got}, {7'h00, exp});
	endtask

	task automatic do_reset(input logic pd);
		bias_low <= pd;
		rst_n <= 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (30) @(posedge clk);
	endtask

	task automatic addr_ptr(input logic [7:0] p);
		logic a;
		u_srs_host_model.start();
		u_srs_host_model.wr_byte({SA, 1'b0}, a);
		chk1(a, 1'b0);
		u_srs_host_model.wr_byte(p, a);
		chk1(a, 1'b0);
	endtask

	task automatic t_bias();
		logic a;
		do_reset(1'b1);
		chk1(port_en, 1'b0);
		bias_low <= 1'b0;
		repeat (30) @(posedge clk);
		chk1(port_en, 1'b0);
		chk1(sda_oe, 1'b0);
		u_srs_host_model.start();
		u_srs_host_model.wr_byte({SA, 1'b0}, a);
		chk1(a, 1'b1);
		u_srs_host_model.stop();
		do_reset(1'b0);
		chk1(port_en, 1'b1);
		chk8(ptr, 8'h00);
	endtask

	task automatic t_wburst();
		logic a;
		stall <= 1'b1;
		fork
			begin
				repeat (800) @(posedge clk);
				stall <= 1'b0;
			end
		join_none
		addr_ptr(8'hfe);
		for (int i = 0; i < 4; i++) begin
			u_srs_host_model.wr_byte(8'h30 + 8'(i), a);
			chk1(a, 1'b0);
		end
		u_srs_host_model.stop();
		repeat (10) @(posedge clk);
		for (int i = 0; i < 4; i++) chk8(mem[8'(8'hfe + i)], 8'h30 + 8'(i));
		chk8(ptr, 8'h02);
	endtask

	task automatic rd_seq(input logic [7:0] p, input logic sr, input logic [7:0] e0);
		logic a;
		logic [7:0] d;
		addr_ptr(p);
		if (!sr) u_srs_host_model.stop();
		u_srs_host_model.start();
		u_srs_host_model.wr_byte({SA, 1'b1}, a);
		chk1(a, 1'b0);
		for (int i = 0; i < 3; i++) begin
			u_srs_host_model.rd_byte(i == 2, d);
			chk8(d, e0 + 8'(i));
		end
		chk1(sda_oe, 1'b0);
		chk1(sda, 1'b1);
		u_srs_host_model.stop();
		chk8(ptr, p + 8'h03);
	endtask

	task automatic t_foreign();
		logic a;
		u_srs_host_model.start();
		u_srs_host_model.wr_byte({SA ^ 7'h01, 1'b0}, a);
		chk1(a, 1'b1);
		u_srs_host_model.wr_byte(8'h55, a);
		chk1(a, 1'b1);
		u_srs_host_model.stop();
		repeat (10) @(posedge clk);
		chk8(ptr, 8'h43);
		chk8(mem[8'h43], 8'h54);
	endtask

	task automatic t_lock();
		logic a;
		hub_att <= 1'b1;
		addr_ptr(8'h10);
		u_srs_host_model.wr_byte(8'h77, a);
		chk1(a, 1'b1);
		u_srs_host_model.stop();
		chk8(ptr, 8'h10);
		addr_ptr(8'hc0);
		u_srs_host_model.wr_byte(8'h9c, a);
		chk1(a, 1'b0);
		u_srs_host_model.stop();
		repeat (10) @(posedge clk);
		chk8(mem[8'h10], 8'h21);
		chk8(mem[8'hc0], 8'h9c);
		hub_att <= 1'b0;
	endtask

	always @(posedge hang) begin
		bad_count++;
		print_verdict();
	end

	initial begin
		repeat (100000) @(posedge clk);
		bad_count++;
		print_verdict();
	end

	initial begin
		t_bias();
		t_wburst();
		rd_seq(8'hfe, 1'b1, 8'h30);
		rd_seq(8'h40, 1'b0, 8'h51);
		t_foreign();
		t_lock();
		do_reset(1'b0);
		chk8(ptr, 8'h00);
		print_verdict();
	end
endmodule

`default_nettype wire
